// >>> verif/cfg_regs_properties.sv
// port assertions for the sensor configuration slice
`timescale 1ns/10ps
`default_nettype none
module cfg_regs_properties (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic selftimed_en_i,
    input wire logic [2:0] prox_rate_o,
    input wire logic [4:0] drive_code_o,
    input wire logic [7:0] drive_ma_o,
    input wire logic light_cont_o,
    input wire logic [2:0] light_rate_o,
    input wire logic light_offset_o,
    input wire logic [2:0] light_avg_o
);
    // ************************************************************
    // one clock domain, reset disables every check
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_ma_scale;
        drive_ma_o == 8'(drive_code_o) * 8'h0A;
    endproperty
    a_ma_scale: assert property (p_ma_scale)
        else $error("drive current not code times step");
    property p_clamp;
        drive_code_o <= 5'h14;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("drive code above clamp");
    property p_drive_reset;
        $rose(rst_b_i) |-> drive_code_o == 5'h02 && drive_ma_o == 8'h14;
    endproperty
    a_drive_reset: assert property (p_drive_reset)
        else $error("drive not at default after reset");
    property p_freeze;
        selftimed_en_i && $past(selftimed_en_i) |-> $stable(drive_code_o);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("drive moved while self-timed");
    property p_light_reset;
        $rose(rst_b_i) |-> {light_cont_o, light_rate_o, light_offset_o,
            light_avg_o} == 8'h05;
    endproperty
    a_light_reset: assert property (p_light_reset)
        else $error("light byte not at default");
    property p_prox_reset;
        $rose(rst_b_i) |-> prox_rate_o == 3'h0;
    endproperty
    a_prox_reset: assert property (p_prox_reset)
        else $error("proximity rate not at default");
    property p_oe_scl_low;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data line moved with bus clock high");
    property p_pull_low;
        sda_oe_o |-> !sda_i;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("enabled data line not low");
    property p_cfg_scl_low;
        $changed({prox_rate_o, light_cont_o, light_rate_o, light_offset_o,
            light_avg_o}) |-> !scl_i ##1 !scl_i;
    endproperty
    a_cfg_scl_low: assert property (p_cfg_scl_low)
        else $error("settings changed outside a write slot");
endmodule : cfg_regs_properties
`default_nettype wire

// >>> verif/i2c_host_model.sv
// two-wire host model: drives bus clock, pulls data low
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    input wire logic sys_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_pull_o
);
    localparam int QTR = 6; // quarter bit in system clocks
    logic [7:0] rd_byte; // last byte read
    event got_byte; // fires for each byte read
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
        rd_byte = 8'h00;
    end
    // wait a quarter bit, then step off the edge
    task automatic qw();
        repeat (QTR) @(posedge sys_clk_i);
        #1;
    endtask : qw
    // one bit: data set with clock low, sampled in clock high
    task automatic bit_x(input logic b, output logic r);
        qw();
        sda_pull_o = !b;
        qw();
        scl_o = 1'b1;
        qw();
        r = sda_line_i;
        qw();
        scl_o = 1'b0;
    endtask : bit_x
    // start or repeated start
    task automatic start();
        qw();
        sda_pull_o = 1'b0;
        qw();
        scl_o = 1'b1;
        qw();
        sda_pull_o = 1'b1;
        qw();
        scl_o = 1'b0;
    endtask : start
    // stop, bus left released
    task automatic stop();
        qw();
        sda_pull_o = 1'b1;
        qw();
        scl_o = 1'b1;
        qw();
        sda_pull_o = 1'b0;
        qw();
    endtask : stop
    // byte out msb first, ack bit returned
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, ack);
    endtask : wr
    // byte in, nack on the last one
    task automatic rd(input logic last);
        logic r;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
        rd_byte = d;
        -> got_byte;
    endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the sensor configuration slice
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [1:0] TAG = 2'h1; // arbitrary value
    localparam logic [6:0] SA = optical_cfg_pkg::BUS_SLAVE_ADDR;
    logic sys_clk, rst_b, sel, scl, pull, sda_oe_o, sda_o, light_cont_o;
    logic light_offset_o, ack;
    logic [2:0] prox_rate_o, light_rate_o, light_avg_o;
    logic [4:0] drive_code_o, cur;
    logic [7:0] drive_ma_o;
    logic [5:0] code;
    logic [15:0] seed;
    logic [7:0] exp_q [$]; // expected read bytes
    int bad_count, n_checks;
    wire logic sda_line = !(pull | (sda_oe_o & !sda_o)); // pulled up
    optical_sensor_config_regs #(.PRODUCT_CODE(4'h5),
        .REVISION_CODE(4'h3), .CAL_TAG(TAG)) uut (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .selftimed_en_i(sel), .prox_rate_o(prox_rate_o),
        .drive_code_o(drive_code_o), .drive_ma_o(drive_ma_o),
        .light_cont_o(light_cont_o), .light_rate_o(light_rate_o),
        .light_offset_o(light_offset_o), .light_avg_o(light_avg_o));
    i2c_host_model host (.sys_clk_i(sys_clk), .sda_line_i(sda_line),
        .scl_o(scl), .sda_pull_o(pull));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : w
    task automatic cmp(input logic [7:0] got, input logic [7:0] e,
        input string m);
        n_checks++;
        if (got !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m,
                got, e);
        end
    endtask : cmp
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // burst write from pointer a, bytes taken from the top of d
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d,
        input int n);
        host.start();
        host.wr({SA, 1'b0}, ack);
        cmp(8'(ack), 8'h00, "address ack");
        host.wr(a, ack);
        for (int i = 0; i < n; i++) host.wr(d[31-8*i -: 8], ack);
        host.stop();
    endtask : reg_wr
    // burst read with pointer set first, expectations queued
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
        input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(e[31-8*i -: 8]);
        host.start();
        host.wr({SA, 1'b0}, ack);
        host.wr(a, ack);
        host.start();
        host.wr({SA, 1'b1}, ack);
        for (int i = 0; i < n; i++) host.rd(i == n - 1);
        host.stop();
    endtask : reg_rd
    task automatic outs(input logic [2:0] p, input logic [4:0] c,
        input logic [7:0] l);
        cmp(8'(prox_rate_o), 8'(p), "prox rate");
        cmp(8'(drive_code_o), 8'(c), "drive code");
        cmp(drive_ma_o, 8'(c) * optical_cfg_pkg::DRIVE_STEP_MA, "mA");
        cmp({light_cont_o, light_rate_o, light_offset_o, light_avg_o}, l,
            "light");
    endtask : outs
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // monitor: each byte read is matched with the oldest note
    initial forever begin
        @(host.got_byte);
        if (exp_q.size() == 0) begin
            bad_count++;
            $display("wrong value at %0t: read byte with no note", $time);
        end else begin
            cmp(host.rd_byte, exp_q.pop_front(), "rd");
        end
    end
    // watchdog
    initial begin
        #3000000;
        bad_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        rst_b = 1'b0;
        sel = 1'b0;
        seed = 16'hD82A;
        w(6);
        rst_b = 1'b1;
        w(6);
        outs(3'h0, 5'h02, 8'h05);
        reg_wr(8'h81, 32'hFF000000, 1);
        reg_rd(8'h81, 32'h53000000, 1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            code = (i == 0) ? 6'h00 : (i == 1) ? 6'h14 :
                (i == 2) ? 6'h15 : seed[13:8];
            cur = (code > 6'h14) ? 5'h14 : code[4:0];
            reg_wr(8'h82, {seed[7:0], seed[15:14], code, seed[11:4],
                8'h00}, 3);
            w(4);
            outs(seed[2:0], cur, seed[11:4]);
            reg_rd(8'h82, {5'h00, seed[2:0], TAG, code, seed[11:4], 8'h00},
                3);
        end
        sel = 1'b1;
        w(2);
        reg_wr(8'h83, 32'h07000000, 1);
        w(4);
        cmp(8'(drive_code_o), 8'(cur), "drive frozen");
        sel = 1'b0;
        w(4);
        cmp(8'(drive_code_o), 8'h07, "drive taken over");
        reg_wr(8'h90, 32'hAA000000, 1);
        reg_rd(8'h90, 32'h00000000, 1);
        reg_rd(8'h80, 32'h00000000, 1);
        host.start();
        host.wr(8'h60, ack);
        cmp(8'(ack), 8'h01, "foreign address");
        host.stop();
        rst_b = 1'b0;
        w(2);
        rst_b = 1'b1;
        w(6);
        outs(3'h0, 5'h02, 8'h05);
        wrap_up();
    end
endmodule : tb_top
bind optical_sensor_config_regs cfg_regs_properties u_props (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .selftimed_en_i(selftimed_en_i), .prox_rate_o(prox_rate_o),
    .drive_code_o(drive_code_o), .drive_ma_o(drive_ma_o),
    .light_cont_o(light_cont_o), .light_rate_o(light_rate_o),
    .light_offset_o(light_offset_o), .light_avg_o(light_avg_o));
`default_nettype wire

// >>> verilog/config_reg_bank.sv
// configuration register bank for the sensor slice
`timescale 1ns/10ps
`default_nettype none
module config_reg_bank #(
    parameter logic [3:0] PRODUCT_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
    parameter logic [1:0] CAL_TAG = 2'h1 // arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic selftimed_en_i,
    reg_access_if.slave bus,
    output logic [2:0] prox_rate_o,
    output logic [4:0] drive_code_o,
    output logic [7:0] drive_ma_o,
    output logic [7:0] light_param_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0] prox_rate; // proximity rate selector
        logic [5:0] drive_field; // programmed drive code
        logic [4:0] drive_code; // code in effect, clamped
        logic [7:0] drive_ma; // drive in effect, milliamperes
        logic [7:0] light; // light parameter byte
    } bank_t;
    bank_t st;
    bank_t next_st;

    // clamp the code to the highest legal step
    function automatic logic [4:0] clamp_drive(input logic [5:0] code);
        if (code > optical_cfg_pkg::DRIVE_MAX) begin
            clamp_drive = optical_cfg_pkg::DRIVE_MAX[4:0];
        end else begin
            clamp_drive = code[4:0];
        end
    endfunction : clamp_drive

    // ************************************************************
    // write decode and takeover of the drive setting
    // ************************************************************
    always_comb begin
        next_st = st;
        if (bus.wr_en) begin
            case (bus.addr)
                optical_cfg_pkg::ADDR_PROX_RATE: begin
                    next_st.prox_rate =
                        bus.wdata[optical_cfg_pkg::PROX_RATE_MSB:0];
                end
                optical_cfg_pkg::ADDR_EMITTER: begin
                    // tag bits dropped, drive bits kept
                    next_st.drive_field =
                        bus.wdata[optical_cfg_pkg::DRIVE_MSB:0];
                end
                optical_cfg_pkg::ADDR_LIGHT: begin
                    next_st.light = bus.wdata;
                end
                default: begin
                    // identity and others ignore writes
                    next_st.light = st.light;
                end
            endcase
        end
        // new drive value only taken while self-timed mode is off
        if (!selftimed_en_i) begin
            next_st.drive_code = clamp_drive(st.drive_field);
            next_st.drive_ma = 8'({3'h0, clamp_drive(st.drive_field)}
                * optical_cfg_pkg::DRIVE_STEP_MA);
        end
    end

    // register the bank
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st.prox_rate <= optical_cfg_pkg::PROX_RATE_RST;
            st.drive_field <= optical_cfg_pkg::DRIVE_RST;
            st.drive_code <= optical_cfg_pkg::DRIVE_RST[4:0];
            st.drive_ma <= 8'({2'h0, optical_cfg_pkg::DRIVE_RST}
                * optical_cfg_pkg::DRIVE_STEP_MA);
            st.light <= optical_cfg_pkg::LIGHT_RST;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        case (bus.addr)
            optical_cfg_pkg::ADDR_IDENTITY: begin
                bus.rdata = {PRODUCT_CODE, REVISION_CODE};
            end
            optical_cfg_pkg::ADDR_PROX_RATE: begin
                bus.rdata = {5'h00, st.prox_rate};
            end
            optical_cfg_pkg::ADDR_EMITTER: begin
                bus.rdata = {CAL_TAG, st.drive_field};
            end
            optical_cfg_pkg::ADDR_LIGHT: begin
                bus.rdata = st.light;
            end
            default: begin
                bus.rdata = optical_cfg_pkg::READ_ZERO;
            end
        endcase
    end

    // outputs straight from flops; drive changes only with mode off, rates change on a write to their own register in either mode
    assign prox_rate_o = st.prox_rate;
    assign drive_code_o = st.drive_code;
    assign drive_ma_o = st.drive_ma;
    assign light_param_o = st.light;
endmodule : config_reg_bank
`default_nettype wire

// >>> verilog/optical_cfg_pkg.sv
// constants and field layouts shared by the configuration register slice
package optical_cfg_pkg;
    // ************************************************************
    // register addresses on the two-wire bus
    // ************************************************************
    localparam logic [7:0] ADDR_FIRST = 8'h80; // command register, lowest
    localparam logic [7:0] ADDR_LAST = 8'h90; // last of seventeen
    localparam logic [7:0] ADDR_IDENTITY = 8'h81; // identity_byte
    localparam logic [7:0] ADDR_PROX_RATE = 8'h82; // proximity_rate
    localparam logic [7:0] ADDR_EMITTER = 8'h83; // emitter_current
    localparam logic [7:0] ADDR_LIGHT = 8'h84; // light_parameters
    localparam logic [6:0] BUS_SLAVE_ADDR = 7'h13; // fixed slave address

    // ************************************************************
    // field layouts
    // ************************************************************
    localparam int PROX_RATE_MSB = 2; // rate selector in bits 2..0
    localparam int DRIVE_MSB = 5; // drive code in bits 5..0
    localparam int CAL_TAG_LSB = 6; // calibration tag in bits 7..6
    localparam int LIGHT_CONT_BIT = 7; // continuous conversion enable
    localparam int LIGHT_RATE_MSB = 6; // light rate bits 6..4
    localparam int LIGHT_RATE_LSB = 4;
    localparam int LIGHT_OFFS_BIT = 3; // offset compensation enable
    localparam int LIGHT_AVG_MSB = 2; // averaging bits 2..0

    // ************************************************************
    // reset values and drive scaling
    // ************************************************************
    localparam logic [2:0] PROX_RATE_RST = 3'h0;
    localparam logic [5:0] DRIVE_RST = 6'h02; // 20 mA after reset
    localparam logic [7:0] LIGHT_RST = 8'h05; // averaging 32 conversions
    localparam logic [5:0] DRIVE_MAX = 6'h14; // highest valid code, 20
    localparam logic [7:0] DRIVE_STEP_MA = 8'h0A; // milliamperes per step
    localparam logic [7:0] READ_ZERO = 8'h00; // unmapped and unused reads

    // ************************************************************
    // bus slave states, gray along the write path and the read loop
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RACK = 4'hC
    } slave_state_t;
endpackage : optical_cfg_pkg

// >>> verilog/optical_sensor_config_regs.sv
// two-wire slave and top of the sensor configuration slice
`timescale 1ns/10ps
`default_nettype none
module optical_sensor_config_regs #(
    parameter logic [3:0] PRODUCT_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
    parameter logic [1:0] CAL_TAG = 2'h1 // arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic selftimed_en_i,
    output logic [2:0] prox_rate_o,
    output logic [4:0] drive_code_o,
    output logic [7:0] drive_ma_o,
    output logic light_cont_o,
    output logic [2:0] light_rate_o,
    output logic light_offset_o,
    output logic [2:0] light_avg_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0] scl_sync; // three-stage pin synchroniser
        logic [2:0] sda_sync; // three-stage pin synchroniser
        logic scl; // filtered clock level
        logic sda; // filtered data level
        optical_cfg_pkg::slave_state_t fsm; // protocol state
        logic [3:0] bit_cnt; // bits in current byte
        logic [7:0] shift; // receive or transmit byte
        logic [7:0] ptr; // register pointer
        logic read_mode; // address byte asked for a read
        logic nack; // master refused further data
        logic drive_low; // pull data line low
        logic wr_en; // write strobe to the bank
        logic [7:0] wdata; // write data to the bank
        logic [7:0] waddr; // write address to the bank
    } slave_t;
    slave_t st;
    slave_t next_st;

    logic scl_rise; // filtered clock rose
    logic scl_fall; // filtered clock fell
    logic start_cond; // data fell while clock high
    logic stop_cond; // data rose while clock high
    logic [7:0] bank_rdata; // byte at the pointer
    logic [7:0] light_byte; // light parameter byte

    reg_access_if rbus ();

    // true for any of the seventeen addresses
    function automatic logic in_window(input logic [7:0] a);
        in_window = (a >= optical_cfg_pkg::ADDR_FIRST) &&
            (a <= optical_cfg_pkg::ADDR_LAST);
    endfunction : in_window

    // ************************************************************
    // line events on filtered levels
    // ************************************************************
    always_comb begin
        scl_rise = !st.scl && (st.scl_sync[2] == st.scl_sync[1])
            && st.scl_sync[1];
        scl_fall = st.scl && (st.scl_sync[2] == st.scl_sync[1])
            && !st.scl_sync[1];
        start_cond = st.scl && st.sda && (st.sda_sync[2] == st.sda_sync[1])
            && !st.sda_sync[1];
        stop_cond = st.scl && !st.sda && (st.sda_sync[2] == st.sda_sync[1])
            && st.sda_sync[1];
    end

    // ************************************************************
    // protocol engine
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.wr_en = 1'b0;
        // shift pins in; only stage 1 reads stage 0
        next_st.scl_sync = {st.scl_sync[1:0], scl_i};
        next_st.sda_sync = {st.sda_sync[1:0], sda_i};
        // a change counts once stages 1 and 2 agree
        if (st.scl_sync[2] == st.scl_sync[1]) begin
            next_st.scl = st.scl_sync[1];
        end
        if (st.sda_sync[2] == st.sda_sync[1]) begin
            next_st.sda = st.sda_sync[1];
        end
        if (stop_cond) begin
            // stop ends any transfer
            next_st.fsm = optical_cfg_pkg::ST_IDLE;
            next_st.drive_low = 1'b0;
        end else if (start_cond) begin
            // start or repeated start, pointer kept
            next_st.fsm = optical_cfg_pkg::ST_ADDR;
            next_st.bit_cnt = 4'h0;
            next_st.drive_low = 1'b0;
        end else begin
            case (st.fsm)
                optical_cfg_pkg::ST_IDLE: begin
                    next_st.drive_low = 1'b0;
                end
                optical_cfg_pkg::ST_ADDR,
                optical_cfg_pkg::ST_PTR,
                optical_cfg_pkg::ST_WDATA: begin
                    // receive eight bits, msb first
                    if (scl_rise) begin
                        next_st.shift = {st.shift[6:0], st.sda};
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                    end else if (scl_fall && st.bit_cnt == 4'h8) begin
                        next_st.bit_cnt = 4'h0;
                        next_st.drive_low = 1'b1;
                        if (st.fsm == optical_cfg_pkg::ST_ADDR) begin
                            if (st.shift[7:1] ==
                                optical_cfg_pkg::BUS_SLAVE_ADDR) begin
                                next_st.read_mode = st.shift[0];
                                next_st.fsm = optical_cfg_pkg::ST_ADDR_ACK;
                            end else begin
                                // not ours, stay off the line
                                next_st.drive_low = 1'b0;
                                next_st.fsm = optical_cfg_pkg::ST_IDLE;
                            end
                        end else if (st.fsm == optical_cfg_pkg::ST_PTR) begin
                            next_st.ptr = st.shift;
                            next_st.fsm = optical_cfg_pkg::ST_PTR_ACK;
                        end else begin
                            // write strobe, then auto-increment
                            next_st.wr_en = in_window(st.ptr);
                            next_st.waddr = st.ptr;
                            next_st.wdata = st.shift;
                            next_st.ptr = st.ptr + 8'h01;
                            next_st.fsm = optical_cfg_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                optical_cfg_pkg::ST_ADDR_ACK: begin
                    // ack clock ends, pick direction
                    if (scl_fall) begin
                        if (st.read_mode) begin
                            next_st.shift = bank_rdata;
                            next_st.drive_low = !bank_rdata[7];
                            next_st.fsm = optical_cfg_pkg::ST_RDATA;
                        end else begin
                            next_st.drive_low = 1'b0;
                            next_st.fsm = optical_cfg_pkg::ST_PTR;
                        end
                    end
                end
                optical_cfg_pkg::ST_PTR_ACK,
                optical_cfg_pkg::ST_WDATA_ACK: begin
                    // release after the ack clock
                    if (scl_fall) begin
                        next_st.drive_low = 1'b0;
                        next_st.fsm = optical_cfg_pkg::ST_WDATA;
                    end
                end
                optical_cfg_pkg::ST_RDATA: begin
                    // send eight bits, msb first
                    if (scl_rise) begin
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st.bit_cnt == 4'h8) begin
                            next_st.drive_low = 1'b0;
                            next_st.ptr = st.ptr + 8'h01;
                            next_st.fsm = optical_cfg_pkg::ST_RACK;
                        end else begin
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.drive_low = !st.shift[6];
                        end
                    end
                end
                optical_cfg_pkg::ST_RACK: begin
                    // master ack means next byte
                    if (scl_rise) begin
                        next_st.nack = st.sda;
                    end else if (scl_fall) begin
                        next_st.bit_cnt = 4'h0;
                        if (!st.nack) begin
                            next_st.shift = bank_rdata;
                            next_st.drive_low = !bank_rdata[7];
                            next_st.fsm = optical_cfg_pkg::ST_RDATA;
                        end else begin
                            next_st.fsm = optical_cfg_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_st.fsm = optical_cfg_pkg::ST_IDLE;
                    next_st.drive_low = 1'b0;
                end
            endcase
        end
    end

    // register the slave
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st.scl_sync <= 3'h7;
            st.sda_sync <= 3'h7;
            st.scl <= 1'b1;
            st.sda <= 1'b1;
            st.fsm <= optical_cfg_pkg::ST_IDLE;
            st.bit_cnt <= 4'h0;
            st.shift <= 8'h00;
            st.ptr <= optical_cfg_pkg::ADDR_FIRST;
            st.read_mode <= 1'b0;
            st.nack <= 1'b0;
            st.drive_low <= 1'b0;
            st.wr_en <= 1'b0;
            st.wdata <= 8'h00;
            st.waddr <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // bank hookup and outputs
    // ************************************************************
    // writes use their latched address, reads the pointer
    assign rbus.wr_en = st.wr_en;
    assign rbus.addr = st.wr_en ? st.waddr : st.ptr;
    assign rbus.wdata = st.wdata;
    assign bank_rdata = rbus.rdata;

    config_reg_bank #(
        .PRODUCT_CODE(PRODUCT_CODE),
        .REVISION_CODE(REVISION_CODE),
        .CAL_TAG(CAL_TAG)
    ) u_bank (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .selftimed_en_i(selftimed_en_i),
        .bus(rbus.slave),
        .prox_rate_o(prox_rate_o),
        .drive_code_o(drive_code_o),
        .drive_ma_o(drive_ma_o),
        .light_param_o(light_byte)
    );

    // light fields split out
    assign light_cont_o = light_byte[optical_cfg_pkg::LIGHT_CONT_BIT];
    assign light_rate_o = light_byte[optical_cfg_pkg::LIGHT_RATE_MSB:
        optical_cfg_pkg::LIGHT_RATE_LSB];
    assign light_offset_o = light_byte[optical_cfg_pkg::LIGHT_OFFS_BIT];
    assign light_avg_o = light_byte[optical_cfg_pkg::LIGHT_AVG_MSB:0];

    // open drain: drive low only
    assign sda_o = 1'b0;
    assign sda_oe_o = st.drive_low;
endmodule : optical_sensor_config_regs
`default_nettype wire

// >>> verilog/reg_access_if.sv
// register access carrier between the bus slave and the register bank
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
    logic wr_en; // one-cycle write strobe
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
    logic [7:0] rdata; // read data at addr
    modport master (output wr_en, output addr, output wdata, input rdata);
    modport slave (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_access_if
`default_nettype wire
